//--- shared/potm_pkg.sv
/*
  constants for the timed pattern unit trigger and mode control block:
  register offsets, field positions, reset values and widths.
  assumes a plain register port with byte-wide data in the low bits.
*/
package potm_pkg;
  // register offsets on the plain register port
  localparam logic [3:0] POTM_OFS_TRIG_SEL = 4'h0;
  localparam logic [3:0] POTM_OFS_MODE = 4'h1;
  localparam logic [3:0] POTM_OFS_NEXT_DATA = 4'h2;
  localparam logic [3:0] POTM_OFS_NEXT_DATA_HI = 4'h3;
  localparam logic [3:0] POTM_OFS_OUT_EN = 4'h4;
  localparam logic [3:0] POTM_OFS_OUT_EN_HI = 4'h5;
  localparam logic [3:0] POTM_OFS_LATCH = 4'h6;
  localparam logic [3:0] POTM_OFS_LATCH_HI = 4'h7;
  // reset values
  localparam logic [7:0] POTM_TRIG_SEL_RST = 8'hff;
  localparam logic [7:0] POTM_MODE_RST = 8'hf0;
  localparam logic [15:0] POTM_DATA_RST = 16'h0000;
  // reserved upper bits of the mode register
  localparam logic [3:0] POTM_MODE_RSVD = 4'hf;
  // geometry
  localparam int POTM_GROUPS = 4;
  localparam int POTM_GROUP_W = 4;
  localparam int POTM_CHANNELS = 4;
  localparam int POTM_SEL_W = 2;
endpackage : potm_pkg

//--- test/potm_timer_model.sv
/*
  timer channel stand-in: free counters raising compare a and b pulses.
  assumes the bench supplies margin and period values per channel.
*/
module potm_timer_model
  import potm_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic run_in,
  input wire logic [31:0] gen_a_in,
  input wire logic [31:0] gen_b_in,
  output logic [POTM_CHANNELS-1:0] match_a_out,
  output logic [POTM_CHANNELS-1:0] match_b_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // one up counter per channel
  logic [7:0] cnt_reg [POTM_CHANNELS];
  // stopped timers keep pulses low so no stray transfer appears
  always @(posedge clock_in or negedge resetn_in)
  begin
    for (int c = 0; c < POTM_CHANNELS; c++)
    begin
      if (!resetn_in || !run_in)
      begin
        cnt_reg[c] <= 8'h00;
        match_a_out[c] <= 1'b0;
        match_b_out[c] <= 1'b0;
      end
      else
      begin
        // b ends period, a marks margin
        match_b_out[c] <= cnt_reg[c] == gen_b_in[8*c+:8];
        match_a_out[c] <= cnt_reg[c] == gen_a_in[8*c+:8];
        cnt_reg[c] <= (cnt_reg[c] == gen_b_in[8*c+:8]) ? 8'h00
                      : cnt_reg[c] + 8'h01;
      end
    end
  end
endmodule // potm_timer_model

//--- test/test_pattern_output_trigger_mode_ctrl.sv
/*
  self-checking bench: random settings, timer pulses, model compare.
  assumes latch writes may meet timer pulses; the model lets pulses win.
*/
module test_pattern_output_trigger_mode_ctrl
  import potm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [3:0] addr_in = 4'h0;
  logic [7:0] wdata_in = 8'h00;
  logic write_in = 1'b0;
  logic read_in = 1'b0;
  logic run = 1'b0;
  logic [31:0] gen_a = 32'h0000_0000;
  logic [31:0] gen_b = 32'h0000_0000;
  logic [3:0] m_a;
  logic [3:0] m_b;
  logic [7:0] rdata;
  logic [15:0] pattern;
  logic [3:0] gload;
  int miscompares = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h0000_7d3b;
  // reference state kept by the bench
  logic [7:0] m_trig;
  logic [7:0] m_mode;
  logic [15:0] m_stg;
  logic [15:0] m_en;
  logic [15:0] m_lat;
  logic [3:0] m_load;

  always #20 clock_in = ~clock_in;

  potm_ctrl u_dut (.clock_in(clock_in), .resetn_in(resetn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in),
    .read_in(read_in), .rdata_out(rdata), .match_a_in(m_a),
    .match_b_in(m_b), .pattern_out(pattern), .group_load_out(gload));
  potm_timer_model u_timer (.clock_in(clock_in), .resetn_in(resetn_in),
    .run_in(run), .gen_a_in(gen_a), .gen_b_in(gen_b),
    .match_a_out(m_a), .match_b_out(m_b));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      miscompares++;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wdata_in <= d;
    write_in <= 1'b1;
    @(posedge clock_in);
    write_in <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] exp, string name);
    @(posedge clock_in);
    addr_in <= a;
    read_in <= 1'b1;
    @(posedge clock_in);
    read_in <= 1'b0;
    @(negedge clock_in);
    check(name, {8'h00, rdata}, {8'h00, exp});
  endtask

  // reference: transfer with pre-edge settings, then apply writes
  always @(posedge clock_in or negedge resetn_in)
  begin
    logic [1:0] sel;
    logic [3:0] mv;
    if (!resetn_in)
    begin
      m_trig = 8'hff;
      m_mode = 8'hf0;
      m_stg = 16'h0000;
      m_en = 16'h0000;
      m_lat = 16'h0000;
      m_load = 4'h0;
    end
    else
    begin
      for (int g = 0; g < 4; g++)
      begin
        sel = m_trig[2*g+:2];
        mv = m_a[sel] ? m_en[4*g+:4]
             : (m_mode[g] && m_b[sel]) ? m_en[4*g+:4] & ~m_stg[4*g+:4]
             : 4'h0;
        m_load[g] = mv != 4'h0;
        m_lat[4*g+:4] = (m_lat[4*g+:4] & ~mv) | (m_stg[4*g+:4] & mv);
      end
      if (write_in)
        case (addr_in)
          4'h0: m_trig = wdata_in;
          4'h1: m_mode = {4'hf, wdata_in[3:0]};
          4'h2: m_stg[7:0] = wdata_in;
          4'h3: m_stg[15:8] = wdata_in;
          4'h4: m_en[7:0] = wdata_in;
          4'h5: m_en[15:8] = wdata_in;
          4'h6: if (m_load[1:0] == 2'b00) m_lat[7:0] = wdata_in;
          4'h7: if (m_load[3:2] == 2'b00) m_lat[15:8] = wdata_in;
          default: ;
        endcase
    end
  end

  // outputs compared every cycle once settled
  always @(negedge clock_in)
  begin
    if (resetn_in)
    begin
      check("pattern", pattern, m_lat);
      check("load", {12'h000, gload}, {12'h000, m_load});
    end
  end

  // watchdog far beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clock_in);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    logic [31:0] r;
    logic [7:0] pb;
    logic [31:0] q;
    repeat (8) @(posedge clock_in);
    resetn_in <= 1'b1;
    rd(4'h0, POTM_TRIG_SEL_RST, "trig_rst");
    rd(4'h1, POTM_MODE_RST, "mode_rst");
    wr(4'h1, 8'h0a);
    rd(4'h1, 8'hfa, "mode_rsvd");
    rd(4'h8, 8'h00, "unmapped");
    for (int t = 0; t < 12; t++)
    begin
      // odd tests rewrite settings while pulses keep coming
      run <= t[0];
      r = rnd();
      wr(4'h0, r[7:0]);
      wr(4'h1, {4'h0, r[11:8]});
      for (int k = 2; k < 6; k++)
      begin
        q = rnd();
        wr(k[3:0], r[8*(k-2)+:8] ^ q[7:0]);
      end
      // odd tests write the latch while pulses may land
      wr(4'h6, q[15:8]);
      wr(4'h7, q[23:16]);
      for (int c = 0; c < 4; c++)
      begin
        r = rnd();
        pb = 8'd4 + {4'h0, r[3:0]};
        gen_b[8*c+:8] <= pb;
        gen_a[8*c+:8] <= r[11:4] % (pb + 8'd1);
      end
      run <= 1'b1;
      repeat (60) @(posedge clock_in);
      rd(4'h0, m_trig, "trig_back");
      run <= 1'b0;
      repeat (2) @(posedge clock_in);
      rd(4'h6, m_lat[7:0], "latch_lo");
      rd(4'h7, m_lat[15:8], "latch_hi");
      $display("test %0d done", t);
    end
    give_verdict();
  end
endmodule // test_pattern_output_trigger_mode_ctrl

//--- verilog/potm_ctrl.sv
/*
  trigger source and output mode control for a 16-bit timed pattern
  unit, with staged data, enables and port latches behind a plain
  register port. assumes timer compare events are one-cycle pulses from
  logic on the same clock, and standby init drives resetn_in low.
*/
// Design decisions made here: the strobed register port and the address map.
//
// Function
// - bits 7:6 pick group 3 trigger
// - bits 5:4 pick group 2 trigger
// - bits 3:2 pick group 1 trigger
// - bits 1:0 pick group 0 trigger
// - field is binary channel index
// - trigger select resets to all ones
// - mode register resets to f0
// - mode upper nibble reads one, fixed
// - mode bit n steers group n
// - normal mode updates on match a
// - nonoverlap updates on a and b
// - enabled bits copy staged data
// - match a moves all enabled bits
// - match b moves only zero bits
module potm_ctrl
  import potm_pkg::*;
(
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic [3:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  output logic [7:0] rdata_out,
  input wire logic [POTM_CHANNELS-1:0] match_a_in,
  input wire logic [POTM_CHANNELS-1:0] match_b_in,
  output logic [15:0] pattern_out,
  output logic [POTM_GROUPS-1:0] group_load_out
);
  // software visible state
  logic [7:0] trig_sel_reg;
  logic [7:0] trig_sel_next;
  logic [3:0] mode_reg; // only the writable lower nibble is stored
  logic [3:0] mode_next;
  logic [15:0] staged_reg; // staged next data
  logic [15:0] staged_next;
  logic [15:0] enable_reg; // per-bit output enable
  logic [15:0] enable_next;
  logic [15:0] latch_reg; // port data latch
  logic [15:0] latch_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [POTM_GROUPS-1:0] load_reg;
  logic [15:0] xfer_latch; // latch after this cycle's triggers
  logic [POTM_GROUPS-1:0] xfer_load;

  // per-group transfer units, one instance each
  genvar g;
  generate
    for (g = 0; g < POTM_GROUPS; g++)
    begin : g_grp
      // group field at bits 2g+1:2g, also
      // mode bit g steers group g
      potm_group_xfer u_xfer (
        .sel_in(trig_sel_reg[g*POTM_SEL_W +: POTM_SEL_W]),
        .nonoverlap_in(mode_reg[g]),
        .match_a_in(match_a_in),
        .match_b_in(match_b_in),
        .staged_in(staged_reg[g*POTM_GROUP_W +: POTM_GROUP_W]),
        .enable_in(enable_reg[g*POTM_GROUP_W +: POTM_GROUP_W]),
        .latch_in(latch_reg[g*POTM_GROUP_W +: POTM_GROUP_W]),
        .latch_next_out(xfer_latch[g*POTM_GROUP_W +: POTM_GROUP_W]),
        .load_out(xfer_load[g])
      );
    end
  endgenerate

  // register writes and latch updates
  always_comb
  begin
    trig_sel_next = trig_sel_reg;
    mode_next = mode_reg;
    staged_next = staged_reg;
    enable_next = enable_reg;
    latch_next = xfer_latch;
    if (write_in)
    begin
      unique case (addr_in)
        POTM_OFS_TRIG_SEL: trig_sel_next = wdata_in;
        POTM_OFS_MODE: mode_next = wdata_in[3:0];
        POTM_OFS_NEXT_DATA: staged_next[7:0] = wdata_in;
        POTM_OFS_NEXT_DATA_HI: staged_next[15:8] = wdata_in;
        POTM_OFS_OUT_EN: enable_next[7:0] = wdata_in;
        POTM_OFS_OUT_EN_HI: enable_next[15:8] = wdata_in;
        // a hardware transfer in the same cycle wins over the write
        POTM_OFS_LATCH:
          latch_next[7:0] = (xfer_load[0] || xfer_load[1]) ?
                            xfer_latch[7:0] : wdata_in;
        POTM_OFS_LATCH_HI:
          latch_next[15:8] = (xfer_load[2] || xfer_load[3]) ?
                             xfer_latch[15:8] : wdata_in;
        default: ; // unmapped writes are dropped
      endcase
    end
  end

  // read mux, data shows in the next cycle only
  always_comb
  begin
    rdata_next = 8'h00;
    if (read_in)
    begin
      unique case (addr_in)
        POTM_OFS_TRIG_SEL: rdata_next = trig_sel_reg;
        POTM_OFS_MODE: rdata_next = {POTM_MODE_RSVD, mode_reg};
        POTM_OFS_NEXT_DATA: rdata_next = staged_reg[7:0];
        POTM_OFS_NEXT_DATA_HI: rdata_next = staged_reg[15:8];
        POTM_OFS_OUT_EN: rdata_next = enable_reg[7:0];
        POTM_OFS_OUT_EN_HI: rdata_next = enable_reg[15:8];
        POTM_OFS_LATCH: rdata_next = latch_reg[7:0];
        POTM_OFS_LATCH_HI: rdata_next = latch_reg[15:8];
        default: rdata_next = 8'h00; // unmapped reads zero
      endcase
    end
  end

  // state registers
  always_ff @(posedge clock_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      trig_sel_reg <= POTM_TRIG_SEL_RST;
      mode_reg <= POTM_MODE_RST[3:0];
      staged_reg <= POTM_DATA_RST;
      enable_reg <= POTM_DATA_RST;
      latch_reg <= POTM_DATA_RST;
      rdata_reg <= 8'h00;
      load_reg <= '0;
    end
    else
    begin
      trig_sel_reg <= trig_sel_next;
      mode_reg <= mode_next;
      staged_reg <= staged_next;
      enable_reg <= enable_next;
      latch_reg <= latch_next;
      rdata_reg <= rdata_next;
      load_reg <= xfer_load;
    end
  end

  assign rdata_out = rdata_reg;
  assign pattern_out = latch_reg;
  assign group_load_out = load_reg;

  a_grp0_normal_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[0] == 1'b0 && match_a_in[trig_sel_reg[1:0]] && !write_in)
    |=> (pattern_out[3:0] == (($past(latch_reg[3:0]) &
         ~$past(enable_reg[3:0])) |
         ($past(staged_reg[3:0]) & $past(enable_reg[3:0])))))
    else $error("group 0 normal transfer wrong");

  a_normal_no_b: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[1] == 1'b0 && !match_a_in[trig_sel_reg[3:2]] && !write_in)
    |=> $stable(pattern_out[7:4]))
    else $error("group 1 changed without match a");

  a_nonov_b_zero: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[2] && !match_a_in[trig_sel_reg[5:4]] &&
     match_b_in[trig_sel_reg[5:4]] && !write_in)
    |=> (pattern_out[11:8] == ($past(latch_reg[11:8]) &
         ~($past(enable_reg[11:8]) & ~$past(staged_reg[11:8])))))
    else $error("match b transfer wrong");

  // match a moves every enabled bit
  a_nonov_a_all: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[3] && match_a_in[trig_sel_reg[7:6]] && !write_in)
    |=> ((pattern_out[15:12] & $past(enable_reg[15:12])) ==
         ($past(staged_reg[15:12]) & $past(enable_reg[15:12]))))
    else $error("match a nonoverlap transfer wrong");

  a_disabled_hold: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!write_in)
    |=> ((pattern_out & ~$past(enable_reg)) ==
         ($past(latch_reg) & ~$past(enable_reg))))
    else $error("disabled bit changed");

  a_mode_rsvd_read: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (read_in && addr_in == POTM_OFS_MODE)
    |=> (rdata_out[7:4] == 4'hf))
    else $error("reserved mode bits not one");

  // group 3 follows its own field
  a_grp3_select: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!match_a_in[trig_sel_reg[7:6]] && !match_b_in[trig_sel_reg[7:6]]
     && !write_in)
    |=> $stable(pattern_out[15:12]))
    else $error("group 3 moved on unselected channel");

  a_load_pulse: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (group_load_out[0]) |-> ($past(xfer_load[0]) &&
      $past(enable_reg[3:0]) != 4'h0))
    else $error("load flag without transfer");

  a_sel_readback: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (write_in && addr_in == POTM_OFS_TRIG_SEL)
    ##1 (read_in && addr_in == POTM_OFS_TRIG_SEL && !write_in)
    |=> (rdata_out == $past(wdata_in, 2)))
    else $error("trigger select readback wrong");

  a_grp1_normal_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[1] == 1'b0 && match_a_in[trig_sel_reg[3:2]] && !write_in)
    |=> (pattern_out[7:4] == (($past(latch_reg[7:4]) &
         ~$past(enable_reg[7:4])) |
         ($past(staged_reg[7:4]) & $past(enable_reg[7:4])))))
    else $error("group 1 normal transfer wrong");

  a_grp2_normal_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[2] == 1'b0 && match_a_in[trig_sel_reg[5:4]] && !write_in)
    |=> (pattern_out[11:8] == (($past(latch_reg[11:8]) &
         ~$past(enable_reg[11:8])) |
         ($past(staged_reg[11:8]) & $past(enable_reg[11:8])))))
    else $error("group 2 normal transfer wrong");

  a_grp3_normal_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[3] == 1'b0 && match_a_in[trig_sel_reg[7:6]] && !write_in)
    |=> (pattern_out[15:12] == (($past(latch_reg[15:12]) &
         ~$past(enable_reg[15:12])) |
         ($past(staged_reg[15:12]) & $past(enable_reg[15:12])))))
    else $error("group 3 normal transfer wrong");

  // group 0 match b clears zeros only
  a_grp0_nonov_b: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[0] && !match_a_in[trig_sel_reg[1:0]] &&
     match_b_in[trig_sel_reg[1:0]] && !write_in)
    |=> (pattern_out[3:0] == ($past(latch_reg[3:0]) &
         ~($past(enable_reg[3:0]) & ~$past(staged_reg[3:0])))))
    else $error("group 0 match b transfer wrong");

  // group 0 match a moves every enabled bit
  a_grp0_nonov_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[0] && match_a_in[trig_sel_reg[1:0]] && !write_in)
    |=> ((pattern_out[3:0] & $past(enable_reg[3:0])) ==
         ($past(staged_reg[3:0]) & $past(enable_reg[3:0]))))
    else $error("group 0 match a nonoverlap transfer wrong");

  // a and b together, a wins
  a_grp1_ab_same: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[1] && match_a_in[trig_sel_reg[3:2]] &&
     match_b_in[trig_sel_reg[3:2]] && !write_in)
    |=> ((pattern_out[7:4] & $past(enable_reg[7:4])) ==
         ($past(staged_reg[7:4]) & $past(enable_reg[7:4]))))
    else $error("group 1 joint event transfer wrong");

  // group 0 normal mode waits for match a
  a_grp0_no_a: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (mode_reg[0] == 1'b0 && !match_a_in[trig_sel_reg[1:0]] && !write_in)
    |=> $stable(pattern_out[3:0]))
    else $error("group 0 changed without match a");

  // select write lands on the next edge
  a_trig_write: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (write_in && addr_in == POTM_OFS_TRIG_SEL)
    |=> (trig_sel_reg == $past(wdata_in)))
    else $error("trigger select write lost");

  // mode write keeps only the group bits
  a_mode_write: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (write_in && addr_in == POTM_OFS_MODE)
    |=> (mode_reg == $past(wdata_in[3:0])))
    else $error("mode write lost");

  // read data only stands after a read strobe
  a_rdata_idle: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (!read_in)
    |=> (rdata_out == 8'h00))
    else $error("read data without read strobe");

  // select is all ones as reset lifts
  a_trig_reset: assert property (@(posedge clock_in)
    $rose(resetn_in) |-> (trig_sel_reg == POTM_TRIG_SEL_RST))
    else $error("trigger select reset value wrong");

  // every group starts in normal mode
  a_mode_reset: assert property (@(posedge clock_in)
    $rose(resetn_in) |-> (mode_reg == POTM_MODE_RST[3:0]))
    else $error("mode reset value wrong");

  // a same-cycle transfer beats a latch write
  a_latch_collide: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (write_in && addr_in == POTM_OFS_LATCH && xfer_load[0])
    |=> (pattern_out[7:0] == $past(xfer_latch[7:0])))
    else $error("latch write beat a transfer");

  // a quiet latch byte takes the software value
  a_latch_write: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (write_in && addr_in == POTM_OFS_LATCH && !xfer_load[0] &&
     !xfer_load[1])
    |=> (pattern_out[7:0] == $past(wdata_in)))
    else $error("latch write lost");

  // a load flag needs a selected event
  a_load_event: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    (group_load_out[1]) |-> ($past(match_a_in[trig_sel_reg[3:2]]) ||
      ($past(mode_reg[1]) && $past(match_b_in[trig_sel_reg[3:2]]))))
    else $error("group 1 load without event");
endmodule // potm_ctrl

//--- verilog/potm_group_xfer.sv
/*
  one output group's transfer logic: picks the selected channel's
  compare events and computes the next port latch nibble.
  assumes compare events are one-cycle pulses on the system clock.
*/
module potm_group_xfer
  import potm_pkg::*;
(
  input wire logic [POTM_SEL_W-1:0] sel_in,
  input wire logic nonoverlap_in,
  input wire logic [POTM_CHANNELS-1:0] match_a_in,
  input wire logic [POTM_CHANNELS-1:0] match_b_in,
  input wire logic [POTM_GROUP_W-1:0] staged_in,
  input wire logic [POTM_GROUP_W-1:0] enable_in,
  input wire logic [POTM_GROUP_W-1:0] latch_in,
  output logic [POTM_GROUP_W-1:0] latch_next_out,
  output logic load_out
);
  logic ev_a; // selected channel match a
  logic ev_b; // selected channel match b
  logic [POTM_GROUP_W-1:0] take; // bits copied this cycle

  // next nibble from current settings and events
  always_comb
  begin
    ev_a = match_a_in[sel_in];
    ev_b = match_b_in[sel_in];
    take = '0;
    if (nonoverlap_in)
    begin
      if (ev_a)
        take = enable_in;
      else if (ev_b)
        take = enable_in & ~staged_in;
    end
    // normal mode on match a only
    else if (ev_a)
      take = enable_in;
    latch_next_out = (latch_in & ~take) | (staged_in & take);
    load_out = |take;
  end
endmodule // potm_group_xfer
